/* id_regs_defines.svh */
`ifndef ID_REGS_DEFINES_SVH
`define ID_REGS_DEFINES_SVH

// ==========================================================================
// Register offsets within the 4KB window (byte addresses).
`define PERIPHERAL_ID_WORD4_OFS 12'hfd0
`define PERIPHERAL_ID_WORD5_OFS 12'hfd4
`define PERIPHERAL_ID_WORD6_OFS 12'hfd8
`define PERIPHERAL_ID_WORD7_OFS 12'hfdc
`define PERIPHERAL_ID_WORD0_OFS 12'hfe0
`define PERIPHERAL_ID_WORD1_OFS 12'hfe4
`define PERIPHERAL_ID_WORD2_OFS 12'hfe8
`define PERIPHERAL_ID_WORD3_OFS 12'hfec
`define COMPONENT_ID_WORD0_OFS 12'hff0
`define COMPONENT_ID_WORD1_OFS 12'hff4
`define COMPONENT_ID_WORD2_OFS 12'hff8
`define COMPONENT_ID_WORD3_OFS 12'hffc

// ==========================================================================
// Field positions.
`define ID_FIELD_HI_BIT 7
`define DESIGNER_ASSIGNED_BIT 3
`define CLASS_LSB 4
`define MINOR_FIX_LSB 4

// ==========================================================================
// Reset and fixed values.
`define MINOR_FIX_RST 4'h0
`define DESIGNER_ASSIGNED_VAL 1'b1
`define CONT_MARKER_BYTE 7'h7f
`define RDATA_RST 32'h0000_0000

`endif

/* id_regs_pkg.sv */
package id_regs_pkg;

    typedef enum logic [1:0]
    {
        AXI_OKAY,
        AXI_EXOKAY,
        AXI_SLVERR,
        AXI_DECERR
    } axi_resp_e;

    typedef enum logic
    {
        RD_IDLE,
        RD_RESP
    } rd_state_e;

endpackage

/* component_identification_regs.sv */
// Behaviour
// RULE1: Words 0, 2, 3 return a preamble byte; word 1 a preamble nibble.
// RULE2: Component word 1 bits 7:4 carry the four-bit component class.
// RULE3: Unused bits, and peripheral words 5 to 7, read as zero.
// RULE4: Four read-only 32-bit component identification words always exist.
// RULE5: Eight read-only 32-bit peripheral identification words always exist.
// RULE6: Component identification words decode at 0xFF0 through 0xFFC.
// RULE7: Peripheral words 0-3 at 0xFE0-0xFEC, words 4-7 at 0xFD0-0xFDC.
// RULE8: Peripheral word 3 bits 7:4 minor-fix, held in zero-reset flops.
// RULE9: Revision and minor-fix fields together form the revision number.
// RULE10: Peripheral word 3 bits 3:0 zero unless customer modified.
// RULE11: Readers must not tell components apart by the modified field.
// RULE12: Peripheral word 2 bits 7:4 hold the revision, counting from zero.
// RULE13: Peripheral word 2 bit 3 reads one: designer code is assigned.
// RULE14: Designer code split over peripheral words 1, 2 and 4.
// RULE15: Continuation count of marker bytes; code is seven bits, not marker.
// RULE16: Designer code names the designer, not the implementer.
// RULE17: Twelve-bit part number in peripheral word 0 and word 1 low nibble.
// RULE18: Peripheral word 4 bits 7:4 give log2 of 4KB blocks used.
// RULE19: Tools should size the component from other fields, not size field.
// RULE20: Writes to any identification word are ignored.
// RULE21: Reads return constants with no side effects from reset onward.
//
// Our own choice: the AXI4-Lite slave port.
`include "id_regs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module component_identification_regs
    import id_regs_pkg::*;
#(
    // Designer and part identity; all default values are arbitrary.
    parameter logic [11:0] PART_NUMBER = 12'h5a1,
    parameter logic [6:0] DESIGNER_CODE = 7'h2a,
    parameter logic [3:0] DESIGNER_CONT = 4'h2,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [3:0] CUSTOMER_MOD = 4'h0,
    parameter logic [3:0] SIZE_LOG2 = 4'h0,
    parameter logic [3:0] COMP_CLASS = 4'h9,
    // Preamble segments; default values are arbitrary.
    parameter logic [7:0] PREAMBLE0 = 8'h11,
    parameter logic [3:0] PREAMBLE1 = 4'h2,
    parameter logic [7:0] PREAMBLE2 = 8'h33,
    parameter logic [7:0] PREAMBLE3 = 8'h44
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    // ======================================================================
    // Identification values.
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [3:0] minor_fix_level_ff;
    rd_state_e rd_state_ff;
    rd_state_e nxt_rd_state;

    // Kept in flops that reset to zero so a metal fix can alter it. [RULE8]
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            minor_fix_level_ff <= `MINOR_FIX_RST;
        else
            minor_fix_level_ff <= minor_fix_level_ff;
    end

    function automatic logic [31:0] id_word(input logic [11:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000; // Unused bits and unmapped words read zero. [RULE3]
        case ({addr[11:2], 2'b00}) // [RULE6] [RULE7]
            `PERIPHERAL_ID_WORD0_OFS: w[7:0] = PART_NUMBER[7:0]; // [RULE17]
            // The code names whoever designed the block. [RULE16]
            `PERIPHERAL_ID_WORD1_OFS:
                w[7:0] = {DESIGNER_CODE[3:0], PART_NUMBER[11:8]}; // [RULE14]
            `PERIPHERAL_ID_WORD2_OFS:
                w[7:0] = {REVISION, `DESIGNER_ASSIGNED_VAL,
                          DESIGNER_CODE[6:4]}; // [RULE12] [RULE13] [RULE9]
            `PERIPHERAL_ID_WORD3_OFS:
                w[7:0] = {minor_fix_level_ff, CUSTOMER_MOD}; // [RULE10]
            `PERIPHERAL_ID_WORD4_OFS:
                w[7:0] = {SIZE_LOG2, DESIGNER_CONT}; // [RULE18] [RULE14]
            `COMPONENT_ID_WORD0_OFS: w[7:0] = PREAMBLE0; // [RULE1]
            `COMPONENT_ID_WORD1_OFS:
                w[7:0] = {COMP_CLASS, PREAMBLE1}; // [RULE2] [RULE1]
            `COMPONENT_ID_WORD2_OFS: w[7:0] = PREAMBLE2; // [RULE1]
            `COMPONENT_ID_WORD3_OFS: w[7:0] = PREAMBLE3; // [RULE1]
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ======================================================================
    // Write channels: accepted in either order, data discarded. [RULE20]
    wire logic aw_hs = awvalid && awready_ff;
    wire logic w_hs = wvalid && wready_ff;
    wire logic b_hs = bvalid_ff && bready;
    wire logic aw_have = aw_got_ff || aw_hs;
    wire logic w_have = w_got_ff || w_hs;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end
        else if (aw_have && w_have && !bvalid_ff)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end
        else
        begin
            aw_got_ff <= aw_have;
            w_got_ff <= w_have;
        end
    end

    // The response goes out once both halves are in; nothing is stored.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            bvalid_ff <= 1'b0;
        else if (aw_have && w_have && !bvalid_ff)
            bvalid_ff <= 1'b1; // [RULE20]
        else if (b_hs)
            bvalid_ff <= 1'b0;
    end

    // Readies drop on capture and return after the response is taken.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end
        else
        begin
            awready_ff <= !aw_have && !(bvalid_ff && !bready);
            wready_ff <= !w_have && !(bvalid_ff && !bready);
        end
    end

    // ======================================================================
    // Read channel.
    wire logic ar_hs = arvalid && arready_ff;
    wire logic r_hs = rvalid_ff && rready;

    always_comb
    begin
        nxt_rd_state = rd_state_ff;
        case (rd_state_ff)
            RD_IDLE:
                if (ar_hs)
                    nxt_rd_state = RD_RESP;
            RD_RESP:
                if (r_hs)
                    nxt_rd_state = RD_IDLE;
            default: nxt_rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rd_state_ff <= RD_IDLE;
        else
            rd_state_ff <= nxt_rd_state;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            arready_ff <= (nxt_rd_state == RD_IDLE);
            rvalid_ff <= (nxt_rd_state == RD_RESP);
        end
    end

    // Reads have no side effect; the word is sampled once per request.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_ff <= `RDATA_RST;
        else if (ar_hs)
            rdata_ff <= id_word(araddr); // [RULE21] [RULE4] [RULE5]
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;

    // Every access is answered OKAY; unmapped words read zero, ignore writes.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bresp <= AXI_OKAY;
            rresp <= AXI_OKAY;
        end
        else
        begin
            bresp <= AXI_OKAY;
            rresp <= AXI_OKAY;
        end
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_read_latency: assert property ( // [RULE21]
        ar_hs |=> rvalid_ff && !arready_ff)
        else $error("read answer not one cycle after address");
    a_read_hold: assert property ( // [RULE21]
        rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff))
        else $error("read data changed while stalled");
    a_upper_zero: assert property ( // [RULE3]
        ar_hs |=> rdata_ff[31:8] == 24'h0)
        else $error("upper identification bits not zero");
    a_pid_reserved: assert property ( // [RULE3]
        ar_hs && araddr[11:2] >= 10'h3f5 && araddr[11:2] <= 10'h3f7
        |=> rdata_ff == 32'h0)
        else $error("reserved peripheral word not zero");
    a_class_field: assert property ( // [RULE2]
        ar_hs && araddr[11:2] == 10'h3fd
        |=> rdata_ff[7:4] == COMP_CLASS && rdata_ff[3:0] == PREAMBLE1)
        else $error("class or preamble nibble wrong");
    a_preamble_byte: assert property ( // [RULE1]
        ar_hs && araddr[11:2] == 10'h3fc |=> rdata_ff[7:0] == PREAMBLE0)
        else $error("preamble byte wrong");
    a_assigned_bit: assert property ( // [RULE13]
        ar_hs && araddr[11:2] == 10'h3fa
        |=> rdata_ff[7:0] == {REVISION, 1'b1, DESIGNER_CODE[6:4]})
        else $error("revision word wrong");
    a_part_low: assert property ( // [RULE17]
        ar_hs && araddr[11:2] == 10'h3f9
        |=> rdata_ff[7:0] == {DESIGNER_CODE[3:0], PART_NUMBER[11:8]})
        else $error("part or designer nibble wrong");
    a_minor_zero: assert property ( // [RULE8]
        minor_fix_level_ff == 4'h0)
        else $error("minor fix level not zero");
    a_code_valid: assert property ( // [RULE15]
        DESIGNER_CODE != `CONT_MARKER_BYTE)
        else $error("designer code equals marker byte");
    a_write_answer: assert property ( // [RULE20]
        awvalid && wvalid && awready_ff && wready_ff && !bvalid_ff
        |=> bvalid_ff ##0 bresp == AXI_OKAY)
        else $error("write not answered next cycle");

    c_write_done: cover property (b_hs);
    c_read_done: cover property (r_hs);
    c_read_stall: cover property (rvalid_ff && !rready ##1 r_hs);
    c_split_write: cover property (aw_hs && !w_hs ##[1:4] w_hs);

endmodule

`default_nettype wire

/* id_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Debug reader: one access at a time, each channel held until taken.
module id_reader_model
(
    input wire logic clock,
    output logic awvalid,
    input wire logic awready,
    output logic [11:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [11:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial
    begin
        awvalid = 1'b0;
        awaddr = 12'h0;
        wvalid = 1'b0;
        wdata = 32'h0;
        bready = 1'b0;
        arvalid = 1'b0;
        araddr = 12'h0;
        rready = 1'b0;
    end

    // A lag above zero stalls rready, so the answer has to stand.
    task automatic rd(input logic [11:0] a, input int lag,
        output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (lag) @(posedge clock);
        rready <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata; // The whole word is kept for identity.
        r = rresp;
        rready <= 1'b0;
    endtask

    // Released lines carry the inverse so stale values are never reused.
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
        output logic [1:0] r);
        logic aw_on;
        logic w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        bready <= 1'b1;
        while (aw_on || w_on)
        begin
            @(posedge clock);
            if (aw_on && awready === 1'b1)
            begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (w_on && wready === 1'b1)
            begin
                w_on = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~v;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* component_identification_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Bench; the identity values below are arbitrary.
module component_identification_regs_tb_top
    import id_regs_pkg::*;
;
    localparam logic [11:0] PART = 12'h3c7;
    localparam logic [6:0] CODE = 7'h55;
    localparam logic [3:0] CONT = 4'h6;
    localparam logic [3:0] REV = 4'h3;
    localparam logic [3:0] SIZE = 4'h1;
    localparam logic [3:0] CLS = 4'h9;
    localparam logic [7:0] PRE0 = 8'h12;
    localparam logic [3:0] PRE1 = 4'h7;
    localparam logic [7:0] PRE2 = 8'h21;
    localparam logic [7:0] PRE3 = 8'h9e;
    logic clock;
    logic sys_rst;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    component_identification_regs #(.PART_NUMBER(PART),
        .DESIGNER_CODE(CODE), .DESIGNER_CONT(CONT), .REVISION(REV),
        .CUSTOMER_MOD(4'h0), .SIZE_LOG2(SIZE), .COMP_CLASS(CLS),
        .PREAMBLE0(PRE0), .PREAMBLE1(PRE1), .PREAMBLE2(PRE2),
        .PREAMBLE3(PRE3)) DUT (.clock(clock), .sys_rst(sys_rst),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));

    id_reader_model reader (.clock(clock), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));

    function automatic logic [31:0] exp_word(input logic [11:0] a);
        case (a)
            12'hfd0: exp_word = {24'h0, SIZE, CONT};
            12'hfe0: exp_word = {24'h0, PART[7:0]};
            12'hfe4: exp_word = {24'h0, CODE[3:0], PART[11:8]};
            12'hfe8: exp_word = {24'h0, REV, 1'b1, CODE[6:4]};
            12'hff0: exp_word = {24'h0, PRE0};
            12'hff4: exp_word = {24'h0, CLS, PRE1};
            12'hff8: exp_word = {24'h0, PRE2};
            12'hffc: exp_word = {24'h0, PRE3};
            default: exp_word = 32'h0;
        endcase
    endfunction

    task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic check_resp(input logic [1:0] got);
        check_word({30'h0, AXI_OKAY}, {30'h0, got});
    endtask

    task automatic give_verdict();
        $display("checked=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic read_all_words(input int lag);
        logic [11:0] a;
        for (int i = 0; i < 12; i++)
        begin
            a = 12'hfd0 + 12'(4 * i);
            reader.rd(a, lag, d, r);
            check_word(exp_word(a), d);
            check_resp(r);
        end
    endtask

    task automatic check_fields();
        reader.rd(12'hff4, 0, d, r);
        check_word(32'(CLS), 32'(d[7:4]));
        reader.rd(12'hfe8, 0, d, r);
        check_word(32'(REV), 32'(d[7:4]));
        check_word(32'h1, 32'(d[3]));
        check_word(32'(CODE[6:4]), 32'(d[2:0]));
        reader.rd(12'hfec, 0, d, r);
        check_word(32'h0, 32'(d[7:4]));
        check_word(32'h0, 32'(d[3:0]));
        reader.rd(12'hfd0, 0, d, r);
        check_word(32'(CONT), 32'(d[3:0]));
        check_word(32'(SIZE), 32'(d[7:4]));
        reader.rd(12'hfe4, 0, d, r);
        check_word(32'(PART[11:8]), 32'(d[3:0]));
    endtask

    // Writing the inverse makes any write that sticks show up.
    task automatic writes_ignored();
        logic [11:0] a;
        for (int i = 0; i < 12; i++)
        begin
            a = 12'hfd0 + 12'(4 * i);
            reader.wr(a, ~exp_word(a), r);
            check_resp(r);
        end
        reader.wr(12'hfcc, 32'hffff_ffff, r);
        check_resp(r);
        reader.rd(12'hfcc, 0, d, r);
        check_word(32'h0, d);
        read_all_words(0);
    endtask

    task automatic reset_mid_run();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        reader.rd(12'hff4, 0, d, r);
        check_word(exp_word(12'hff4), d);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // The whole run needs well under a thousand cycles.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        read_all_words(0);
        check_fields();
        writes_ignored();
        read_all_words(3);
        reset_mid_run();
        give_verdict();
    end
endmodule

`default_nettype wire
